// *** vdio_pkg.sv ***
`default_nettype none
package vdio_pkg;
  localparam int VDIO_N = 16;
  localparam int VDIO_FW = 6;
  localparam logic [7:0] VDIO_VI_EN = 8'h00;
  localparam logic [7:0] VDIO_VI_PODEF = 8'h04;
  localparam logic [7:0] VDIO_VI_LEVEL = 8'h08;
  localparam logic [7:0] VDIO_VI_LSEL = 8'h0c;
  localparam logic [7:0] VDIO_VO_EN = 8'h10;
  localparam logic [7:0] VDIO_VO_DEF = 8'h14;
  localparam logic [7:0] VDIO_VO_LSEL = 8'h18;
  localparam logic [7:0] VDIO_VO_LEVEL = 8'h1c;
  localparam logic [7:0] VDIO_FAULT = 8'h20;
  localparam logic [7:0] VDIO_IRQ_STAT = 8'h24;
  localparam logic [7:0] VDIO_IRQ_MASK = 8'h28;
  localparam logic [15:0] VDIO_FAULT_CODE = 16'h0082;
  localparam int VDIO_EV_CONFLICT = 0;
  localparam int VDIO_EV_VO_CHANGE = 1;

  typedef logic [VDIO_N-1:0][VDIO_FW-1:0] vdio_fsel_t;

  typedef struct packed {
    logic [VDIO_N-1:0] assigned;
    logic [VDIO_N-1:0] active;
  } vdio_vo_func_t;

  typedef struct packed {
    logic vi_en;
    logic [15:0] vi_podef;
    logic [15:0] vi_level;
    logic [15:0] vi_lsel;
    logic [15:0] vi_prev;
    logic [15:0] vi_act;
    logic vo_en;
    logic [15:0] vo_def;
    logic [15:0] vo_lsel;
    logic [15:0] vo_level;
    logic conflict;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic loaded;
    logic ap_wr;
    logic rd_wait;
    logic [7:0] ap_addr;
    logic [31:0] hrdata;
  } vdio_state_t;

  localparam vdio_state_t VDIO_RST = '0;
endpackage
`default_nettype wire

// *** vdio_top.sv ***
// Design decisions made here: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module vdio_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [15:0] nv_poweron_default,
  input wire logic [63:0] hw_func_used,
  input wire vdio_pkg::vdio_fsel_t vi_func,
  input wire vdio_pkg::vdio_vo_func_t vo_func,
  output logic [15:0] vi_active,
  output logic [15:0] virtual_output,
  output logic [15:0] poweron_default,
  output logic input_function_conflict_fault,
  output logic irq
);
  import vdio_pkg::*;

  vdio_state_t s_q;
  vdio_state_t s_d;
  logic take;
  logic conflict_now;
  logic wr;
  logic [15:0] wd;

  function automatic logic [31:0] rd_word(input vdio_state_t s, input logic [7:0] a);
    logic [31:0] r;
    r = '0;
    case (a)
      VDIO_VI_EN: r[0] = s.vi_en;
      VDIO_VI_PODEF: r[15:0] = s.vi_podef;
      VDIO_VI_LEVEL: r[15:0] = s.vi_level;
      VDIO_VI_LSEL: r[15:0] = s.vi_lsel;
      VDIO_VO_EN: r[0] = s.vo_en;
      VDIO_VO_DEF: r[15:0] = s.vo_def;
      VDIO_VO_LSEL: r[15:0] = s.vo_lsel;
      VDIO_VO_LEVEL: r[15:0] = s.vo_level;
      VDIO_FAULT: r[15:0] = s.conflict ? VDIO_FAULT_CODE : 16'h0000;
      VDIO_IRQ_STAT: r[1:0] = s.irq_stat;
      VDIO_IRQ_MASK: r[1:0] = s.irq_mask;
      default: r = '0;
    endcase
    return r;
  endfunction

  // Address phase accepted only while the bus is ready
  assign take = hsel & hready & htrans[1];
  assign wr = s_q.ap_wr;
  assign wd = hwdata[15:0];

  always_comb begin
    conflict_now = 1'b0;
    for (int i = 0; i < VDIO_N; i++) begin
      if (vi_func[i] != '0 && hw_func_used[vi_func[i]]) begin
        conflict_now = 1'b1;
      end
    end
  end

  always_comb begin
    s_d = s_q;
    // Register writes land in the data phase
    if (wr) begin
      case (s_q.ap_addr)
        VDIO_VI_EN: s_d.vi_en = hwdata[0];
        VDIO_VI_PODEF: s_d.vi_podef = wd;
        VDIO_VI_LEVEL: s_d.vi_level = wd;
        VDIO_VI_LSEL: s_d.vi_lsel = wd;
        VDIO_VO_EN: s_d.vo_en = hwdata[0];
        VDIO_VO_DEF: s_d.vo_def = wd;
        VDIO_VO_LSEL: s_d.vo_lsel = wd;
        VDIO_IRQ_MASK: s_d.irq_mask = hwdata[1:0];
        default: s_d.vo_level = s_q.vo_level;
      endcase
    end
    // Single load of the stored default after reset release
    if (!s_q.loaded) begin
      s_d.loaded = 1'b1;
      s_d.vi_level = nv_poweron_default;
      s_d.vi_podef = nv_poweron_default;
    end
    // Bit n of the level word is virtual input n+1
    s_d.vi_prev = s_q.vi_level;
    for (int i = 0; i < VDIO_N; i++) begin
      if (!s_q.vi_en) begin
        s_d.vi_act[i] = 1'b0;
      end else if (s_q.vi_lsel[i]) begin
        s_d.vi_act[i] = s_q.vi_level[i] & ~s_q.vi_prev[i];
      end else begin
        s_d.vi_act[i] = s_q.vi_level[i];
      end
    end
    for (int i = 0; i < VDIO_N; i++) begin
      if (!vo_func.assigned[i]) begin
        s_d.vo_level[i] = s_q.vo_def[i];
      end else if (!s_q.vo_en) begin
        s_d.vo_level[i] = 1'b0;
      end else begin
        s_d.vo_level[i] = vo_func.active[i] ^ s_q.vo_lsel[i];
      end
    end
    s_d.conflict = conflict_now;
    // Write-one-to-clear, a new event in the same cycle wins
    if (wr && s_q.ap_addr == VDIO_IRQ_STAT) begin
      s_d.irq_stat = s_q.irq_stat & ~hwdata[1:0];
    end
    if (conflict_now && !s_q.conflict) begin
      s_d.irq_stat[VDIO_EV_CONFLICT] = 1'b1;
    end
    if (s_d.vo_level != s_q.vo_level) begin
      s_d.irq_stat[VDIO_EV_VO_CHANGE] = 1'b1;
    end
    // Reads take one wait state so a preceding write is seen
    s_d.ap_wr = take & hwrite;
    s_d.rd_wait = take & ~hwrite;
    if (take) begin
      s_d.ap_addr = haddr[7:0];
    end
    if (s_q.rd_wait) begin
      s_d.hrdata = rd_word(s_q, s_q.ap_addr);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= VDIO_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign hreadyout = ~s_q.rd_wait;
  assign hresp = 1'b0;
  assign hrdata = s_q.hrdata;
  assign vi_active = s_q.vi_act;
  assign virtual_output = s_q.vo_level;
  assign poweron_default = s_q.vi_podef;
  assign input_function_conflict_fault = s_q.conflict;
  assign irq = |(s_q.irq_stat & s_q.irq_mask);

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_conflict;
    conflict_now |=> input_function_conflict_fault ##0 rd_word(s_q, VDIO_FAULT) == 32'h0000_0082;
  endproperty
  a_conflict: assert property (p_conflict) else $error("conflict fault not raised");

  property p_no_conflict;
    !conflict_now |=> !input_function_conflict_fault;
  endproperty
  a_no_conflict: assert property (p_no_conflict) else $error("spurious conflict fault");

  property p_load;
    $rose(s_q.loaded) |-> s_q.vi_level == $past(nv_poweron_default);
  endproperty
  a_load: assert property (p_load) else $error("power-on level not loaded");

  property p_runtime;
    wr && s_q.loaded && s_q.ap_addr == VDIO_VI_LEVEL |=> s_q.vi_level == $past(hwdata[15:0]);
  endproperty
  a_runtime: assert property (p_runtime) else $error("runtime level write lost");

  property p_edge;
    s_q.vi_act[0] && $past(s_q.vi_lsel[0]) |-> $past(s_q.vi_level[0]) && !$past(s_q.vi_level[0], 2);
  endproperty
  a_edge: assert property (p_edge) else $error("edge input active without edge");

  property p_podef_late;
    s_q.loaded && wr && s_q.ap_addr == VDIO_VI_PODEF |=> $stable(s_q.vi_level);
  endproperty
  a_podef_late: assert property (p_podef_late) else $error("default acted before power cycle");

  property p_vo_default;
    1'b1 |=> ((s_q.vo_level ^ $past(s_q.vo_def)) & ~$past(vo_func.assigned)) == 16'h0000;
  endproperty
  a_vo_default: assert property (p_vo_default) else $error("unassigned output off default");

  property p_vo_off;
    !s_q.vo_en |=> (s_q.vo_level & $past(vo_func.assigned)) == 16'h0000;
  endproperty
  a_vo_off: assert property (p_vo_off) else $error("disabled output driven");

  property p_vo_polarity;
    s_q.vo_en && vo_func.assigned[0] && vo_func.active[0] |=> s_q.vo_level[0] == !$past(s_q.vo_lsel[0]);
  endproperty
  a_vo_polarity: assert property (p_vo_polarity) else $error("output polarity wrong");

  property p_vi_off;
    !s_q.vi_en |=> vi_active == 16'h0000;
  endproperty
  a_vi_off: assert property (p_vi_off) else $error("disabled input active");

  property p_rd_wait;
    take && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");

  // A rising conflict marks the status bit even under a clearing write
  property p_set_wins;
    conflict_now && !s_q.conflict |=> s_q.irq_stat[VDIO_EV_CONFLICT];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("conflict event lost");

  property p_w1c;
    wr && s_q.ap_addr == VDIO_IRQ_STAT && hwdata[VDIO_EV_CONFLICT] && !(conflict_now && !s_q.conflict)
      |=> !s_q.irq_stat[VDIO_EV_CONFLICT];
  endproperty
  a_w1c: assert property (p_w1c) else $error("conflict status not cleared");

  property p_vo_change;
    s_q.vo_level != $past(s_q.vo_level) |-> s_q.irq_stat[VDIO_EV_VO_CHANGE];
  endproperty
  a_vo_change: assert property (p_vo_change) else $error("output change not flagged");

  property p_vo_ro;
    wr && s_q.ap_addr == VDIO_VO_LEVEL && $stable(s_q.vo_def) && $stable(s_q.vo_lsel)
      && $stable(s_q.vo_en) && $stable(vo_func) |=> $stable(s_q.vo_level);
  endproperty
  a_vo_ro: assert property (p_vo_ro) else $error("read-only output level written");

  c_conflict: cover property ($rose(input_function_conflict_fault));
  c_vo_driven: cover property (s_q.vo_en && (s_q.vo_level & vo_func.assigned) != 16'h0000);
  c_edge: cover property (s_q.vi_en && s_q.vi_lsel[0] && vi_active[0]);
  c_irq: cover property ($rose(irq));
endmodule
`default_nettype wire

// *** vdio_host.sv ***
`timescale 1ns/1ns
`default_nettype none
module vdio_host (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  import vdio_pkg::*;
  initial begin
    hsel = 1'b1;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = '0;
  end
  // One single word transfer, entered just after a rising edge
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (!hready) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (!hready) @(posedge hclk);
    q = hrdata;
  endtask
  task automatic set_vo(input logic [15:0] def);
    logic [31:0] q;
    xfer(VDIO_VO_DEF, 1'b1, {16'h0, def}, q);
    xfer(VDIO_VO_LSEL, 1'b1, {16'h0, ~def}, q);
  endtask
endmodule
`default_nettype wire

// *** vdio_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import vdio_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel, hwrite, hreadyout, hresp, fault, irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] nv, vi_active, vout, podef;
  logic [63:0] hw_used;
  vdio_fsel_t vi_func;
  vdio_vo_func_t vo_func;
  int n_mismatch = 0;
  int check_count = 0;
  int n_pulse = 0;
  int p0;
  always #5 hclk = ~hclk;
  always @(negedge hclk) if (vi_active[0]) n_pulse++;
  vdio_host i_host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  vdio_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .nv_poweron_default(nv),
    .hw_func_used(hw_used), .vi_func(vi_func), .vo_func(vo_func), .vi_active(vi_active),
    .virtual_output(vout), .poweron_default(podef),
    .input_function_conflict_fault(fault), .irq(irq));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    i_host.xfer(a, 1'b1, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    i_host.xfer(a, 1'b0, 32'h0, q);
    chk(q, exp);
  endtask
  task automatic settle;
    repeat (3) @(posedge hclk);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge hclk);
    n_mismatch++;
    wrap_up;
  end
  initial begin
    nv = 16'ha5c3;
    hw_used = 64'h1;
    vi_func = '0;
    vo_func = '0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(VDIO_VI_PODEF, 32'ha5c3);
    rdc(VDIO_VI_LEVEL, 32'ha5c3);
    rdc(VDIO_VI_EN, 32'h0);
    rdc(VDIO_VO_EN, 32'h0);
    rdc(VDIO_VO_LEVEL, 32'h0);
    chk(32'(vi_active), 32'h0);
    chk(32'(fault), 32'h0);
    $display("reset test done");
    wr(VDIO_VI_PODEF, 32'h1234);
    wr(VDIO_VI_EN, 32'h1);
    wr(VDIO_VI_LEVEL, 32'h8001);
    settle;
    chk(32'(vi_active), 32'h8001);
    chk(32'(podef), 32'h1234);
    rdc(VDIO_VI_LEVEL, 32'h8001);
    wr(VDIO_VI_EN, 32'h0);
    settle;
    chk(32'(vi_active), 32'h0);
    wr(VDIO_VI_EN, 32'h1);
    wr(VDIO_VI_LSEL, 32'h1);
    wr(VDIO_VI_LEVEL, 32'h0);
    settle;
    p0 = n_pulse;
    wr(VDIO_VI_LEVEL, 32'h1);
    settle;
    settle;
    chk(32'(n_pulse - p0), 32'h1);
    $display("input test done");
    vi_func[3] <= 6'd5;
    hw_used <= 64'h21;
    wr(VDIO_IRQ_MASK, 32'h1);
    settle;
    chk(32'(fault), 32'h1);
    chk(32'(irq), 32'h1);
    rdc(VDIO_FAULT, {16'h0, VDIO_FAULT_CODE});
    vi_func[3] <= 6'd0;
    settle;
    wr(VDIO_IRQ_STAT, 32'h3);
    settle;
    chk(32'(irq), 32'h0);
    rdc(VDIO_FAULT, 32'h0);
    $display("conflict test done");
    vo_func <= {16'h0003, 16'h0001};
    i_host.set_vo(16'h8000);
    settle;
    chk(32'(vout), 32'h8000);
    wr(VDIO_VO_EN, 32'h1);
    settle;
    chk(32'(vout), 32'h8002);
    rdc(VDIO_VO_LEVEL, 32'h8002);
    wr(VDIO_VO_LEVEL, 32'h0);
    rdc(VDIO_VO_LEVEL, 32'h8002);
    rdc(VDIO_IRQ_STAT, 32'h2);
    rdc(8'h40, 32'h0);
    chk(32'(hresp), 32'h0);
    $display("output test done");
    wrap_up;
  end
endmodule
`default_nettype wire
